// file: design/event_status_pkg.sv
package event_status_pkg;

   // ==========================================================
   // Register map and frame layout
   // ==========================================================
   localparam logic [5:0]  ADDR_EVENT_STATUS  = 6'h02;
   localparam logic [5:0]  ADDR_CHECKSUM      = 6'h03;
   localparam logic [5:0]  FRAME_BITS         = 6'h20;
   localparam logic [5:0]  FRAME_OVERRUN      = 6'h21;
   localparam logic [5:0]  HEADER_LAST        = 6'h07;
   localparam logic [5:0]  LAST_BIT_IDX       = 6'h1f;
   localparam int          CMD_RW_BIT         = 31;
   localparam int          ADDR_MSB           = 29;
   localparam int          ADDR_LSB           = 24;
   localparam int          DATA_WIDTH         = 24;
   localparam int          CHECKSUM_WIDTH     = 16;

   // ==========================================================
   // Event status fields
   // ==========================================================
   localparam int          BIT_FACTORY_LOAD   = 13;
   localparam int          BIT_CHECKSUM_DONE  = 8;
   localparam int          BIT_UNDERVOLTAGE   = 7;
   localparam int          BIT_OVERVOLTAGE    = 6;
   localparam int          BIT_THERMAL_WARN   = 5;
   localparam int          BIT_THERMAL_SHUT   = 4;
   localparam int          BIT_SWITCH_CHANGE  = 3;
   localparam int          BIT_PARITY_ERROR   = 2;
   localparam int          BIT_FRAMING_ERROR  = 1;
   localparam int          BIT_POWER_ON       = 0;
   localparam int          NUM_LEVELS         = 4;
   localparam logic [23:0] STATUS_RESET       = 24'h000001;
   localparam logic [23:0] STATUS_CLEARED     = 24'h000000;
   localparam logic [23:0] STATUS_IMPL_MASK   = 24'h0021ff;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [1:0] {
      INIT_LOAD,
      INIT_CHECK,
      INIT_RUN
   } init_e;

   // Monitored conditions, index 0..3 map onto status bits 4..7
   typedef struct packed {
      logic undervoltage;
      logic overvoltage;
      logic thermal_warning;
      logic thermal_shutdown;
   } level_s;

   typedef struct packed {
      logic   factory_loaded;
      logic   selfcheck_done;
      logic   selfcheck_err;
      logic   checksum_done;
      logic   switch_crossing;
      logic   poll_first_done;
      level_s levels;
   } event_in_s;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic si;
   } spi_in_s;

   typedef struct packed {
      init_e       init;
      logic [23:0] status;
      logic [3:0]  lvl_prev;
      logic [2:0]  cs_sync;
      logic [2:0]  sclk_sync;
      logic [1:0]  si_sync;
      logic [5:0]  bit_cnt;
      logic [31:0] rx;
      logic        rx_par;
      logic [31:0] tx;
      logic        so;
      logic        int_n;
   } state_s;

endpackage : event_status_pkg

// file: design/event_status_register_readclear.sv
`timescale 1ns/100ps
// Notes on behaviour
// - A valid read frame addressed to the event status register clears the latched event bits that it shifted out.
// - The active-low interrupt output is released at the chip-select rising edge that ends that read if no flag is left set.
// - After factory settings are loaded at start-up a self-check is run on them.
// - A failing self-check sets the factory-load error flag together with the power-on flag.
// - Checksum completion sets the checksum-done flag and its result reads at offset 3h.
// - The checksum-done flag is zero before and during a calculation and after a status read.
// - Entry into undervoltage sets the undervoltage flag.
// - Exit from undervoltage also sets the undervoltage flag.
// - Overvoltage, thermal warning and thermal shutdown flags set on both entry and exit.
// - The switch-change flag sets on any threshold crossing and after the first polling cycle.
// - The parity-error flag sets when the last received serial frame has bad parity.
// - The other-event indicator is high while undervoltage, overvoltage, checksum or load error is set.
module event_status_register_readclear
   import event_status_pkg::*;
(
   // Clock and reset
   input  wire logic                                      REF_CLK,
   input  wire logic                                      RST_N,
   // Serial pins
   input  wire event_status_pkg::spi_in_s                 SPI_IN,
   output wire logic                                      SO,
   output wire logic                                      SO_OE,
   // Interrupt pin
   output wire logic                                      INT_N,
   // Events from the monitors
   input  wire event_status_pkg::event_in_s               EVENTS,
   input  wire logic [event_status_pkg::CHECKSUM_WIDTH-1:0] CHECKSUM_RESULT,
   // Start-up sequencing
   output wire logic                                      SELFCHECK_START,
   output wire logic                                      INIT_DONE,
   // Status view
   output wire logic                                      OTHER_EVENT,
   output wire logic [23:0]                               EVENT_STATUS
);
   import event_status_pkg::*;

   state_s q;
   state_s n;

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      logic        cs_fall;
      logic        cs_rise;
      logic        sck_rise;
      logic        sck_fall;
      logic        active;
      logic        clear;
      logic [23:0] clr_mask;
      logic        oei;
      logic [23:0] set;
      logic [31:0] rx_next;
      logic [3:0]  lvl_now;
      logic [7:0]  header;
      logic [5:0]  idx;
      cs_fall  = 1'b0;
      cs_rise  = 1'b0;
      sck_rise = 1'b0;
      sck_fall = 1'b0;
      active   = 1'b0;
      clear    = 1'b0;
      clr_mask = '0;
      oei      = 1'b0;
      set      = '0;
      rx_next  = '0;
      lvl_now  = '0;
      header   = '0;
      idx      = '0;
      n        = q;

      // Only stage 1 and the history stage are read; stage 0 stays private to the synchroniser
      // Serial clock levels shorter than about one reference cycle may lose an edge
      n.cs_sync   = {q.cs_sync[1:0], SPI_IN.cs_n};
      n.sclk_sync = {q.sclk_sync[1:0], SPI_IN.sclk};
      n.si_sync   = {q.si_sync[0], SPI_IN.si};
      cs_fall  = q.cs_sync[2] & ~q.cs_sync[1];
      cs_rise  = ~q.cs_sync[2] & q.cs_sync[1];
      sck_rise = ~q.sclk_sync[2] & q.sclk_sync[1];
      sck_fall = q.sclk_sync[2] & ~q.sclk_sync[1];
      active   = ~q.cs_sync[1];

      // ========================================================
      // Start-up: load, then verify what was loaded
      // ========================================================
      case (q.init)
         INIT_LOAD: begin
            if (EVENTS.factory_loaded) begin
               n.init = INIT_CHECK;
            end
         end
         INIT_CHECK: begin
            if (EVENTS.selfcheck_done) begin
               n.init = INIT_RUN;
               if (EVENTS.selfcheck_err) begin
                  set[BIT_FACTORY_LOAD] = 1'b1;
                  set[BIT_POWER_ON]     = 1'b1;
               end
            end
         end
         INIT_RUN: begin
            // Held until the next reset, which is how a software reset reloads the settings
            n.init = INIT_RUN;
         end
         default: begin
            n.init = INIT_LOAD;
         end
      endcase

      // ========================================================
      // Event capture
      // ========================================================
      // Pulses arrive on this clock and last one cycle, so no edge detect is needed on them
      set[BIT_CHECKSUM_DONE] = EVENTS.checksum_done;
      set[BIT_SWITCH_CHANGE] = EVENTS.switch_crossing | EVENTS.poll_first_done;
      // History starts at zero, so a fault already present at reset release is reported once
      lvl_now = EVENTS.levels;
      // Any change of level counts, so leaving a fault is reported like entering it
      for (int i = 0; i < NUM_LEVELS; i++) begin
         set[BIT_THERMAL_SHUT + i] = lvl_now[i] ^ q.lvl_prev[i];
      end
      n.lvl_prev = lvl_now;

      oei = q.status[BIT_UNDERVOLTAGE] | q.status[BIT_OVERVOLTAGE] |
            q.status[BIT_CHECKSUM_DONE] | q.status[BIT_FACTORY_LOAD];
      header = {q.status[BIT_POWER_ON], oei, q.status[BIT_FRAMING_ERROR], q.status[BIT_PARITY_ERROR],
                q.status[BIT_SWITCH_CHANGE], q.status[BIT_THERMAL_SHUT], q.status[BIT_THERMAL_WARN], 1'b0};

      // ========================================================
      // Serial frame
      // ========================================================
      // Frame: write bit, unused bit, six address bits, data, and a last bit that makes the ones count odd
      // The answer is a header byte of flags, then 24 data bits, both MSB first
      // Header is frozen at the start of the frame so it cannot change under the host
      if (cs_fall) begin
         n.bit_cnt = '0;
         n.rx_par  = 1'b0;
         n.tx      = {header, {DATA_WIDTH{1'b0}}};
         n.so      = header[7];
      end else if (active && sck_rise) begin
         rx_next  = {q.rx[30:0], q.si_sync[1]};
         n.rx     = rx_next;
         n.rx_par = q.rx_par ^ q.si_sync[1];
         // Counter stops at overrun so an overlong frame still reads as a framing fault
         if (q.bit_cnt != FRAME_OVERRUN) begin
            n.bit_cnt = q.bit_cnt + 6'h01;
         end
         // Data is chosen once the address byte is in, so a read answers in its own frame
         if (q.bit_cnt == HEADER_LAST) begin
            case (rx_next[5:0])
               ADDR_EVENT_STATUS: n.tx[DATA_WIDTH-1:0] = q.status;
               ADDR_CHECKSUM:     n.tx[DATA_WIDTH-1:0] = {8'h00, CHECKSUM_RESULT};
               default:           n.tx[DATA_WIDTH-1:0] = '0;
            endcase
         end
      end else if (active && sck_fall && q.bit_cnt < FRAME_BITS) begin
         idx  = LAST_BIT_IDX - q.bit_cnt;
         n.so = q.tx[idx[4:0]];
      end

      // A write or a read of another address leaves the flags alone; a faulty frame sets the framing or parity flag
      if (cs_rise) begin
         if (q.bit_cnt != FRAME_BITS) begin
            set[BIT_FRAMING_ERROR] = 1'b1;
         end else if (!q.rx_par) begin
            set[BIT_PARITY_ERROR] = 1'b1;
         end else if (!q.rx[CMD_RW_BIT] && q.rx[ADDR_MSB:ADDR_LSB] == ADDR_EVENT_STATUS) begin
            clear = 1'b1;
         end
      end

      // Only the snapshot shifted out to the host is cleared; anything latched after it waits for the next read
      if (clear) begin
         clr_mask = q.tx[DATA_WIDTH-1:0];
      end

      // Fresh events are merged after the clear so none is lost
      n.status = ((q.status & ~clr_mask) | set) & STATUS_IMPL_MASK;
      // The pin follows the next status, so it drops in the same cycle as the flag it reports
      n.int_n  = ~|n.status;
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         q.init      <= INIT_LOAD;
         q.status    <= STATUS_RESET;
         q.lvl_prev  <= '0;
         q.cs_sync   <= 3'h7;
         q.sclk_sync <= 3'h0;
         q.si_sync   <= 2'h0;
         q.bit_cnt   <= '0;
         q.rx        <= '0;
         q.rx_par    <= 1'b0;
         q.tx        <= '0;
         q.so        <= 1'b0;
         q.int_n     <= 1'b0;
      end else begin
         q <= n;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   // The data pin is only driven while the synchronised select is low
   assign SO              = q.so;
   assign SO_OE           = ~q.cs_sync[1];
   assign INT_N           = q.int_n;
   assign SELFCHECK_START = (q.init == INIT_CHECK);
   assign INIT_DONE       = (q.init == INIT_RUN);
   assign OTHER_EVENT     = q.status[BIT_UNDERVOLTAGE] | q.status[BIT_OVERVOLTAGE] |
                            q.status[BIT_CHECKSUM_DONE] | q.status[BIT_FACTORY_LOAD];
   assign EVENT_STATUS    = q.status;

endmodule : event_status_register_readclear

// file: bench/event_status_chk.sv
`timescale 1ns/100ps
module event_status_chk
   import event_status_pkg::*;
(
   // Clock and reset
   input wire logic                        REF_CLK,
   input wire logic                        RST_N,
   // Watched signals
   input wire event_status_pkg::event_in_s EVENTS,
   input wire logic                        INT_N,
   input wire logic                        SELFCHECK_START,
   input wire logic                        INIT_DONE,
   input wire logic                        OTHER_EVENT,
   input wire logic [23:0]                 EVENT_STATUS
);
   // ==========================================================
   // Status relations
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   sequence s_load_fail; SELFCHECK_START && EVENTS.selfcheck_done && EVENTS.selfcheck_err; endsequence
   sequence s_load_flags; EVENT_STATUS[13] && EVENT_STATUS[0] && INIT_DONE; endsequence
   property p_load_error; s_load_fail |=> s_load_flags; endproperty
   property p_init_order; $rose(INIT_DONE) |-> $past(SELFCHECK_START); endproperty
   property p_reserved; (EVENT_STATUS & ~STATUS_IMPL_MASK) == 24'h0; endproperty
   property p_int_level; INT_N == (EVENT_STATUS == 24'h0); endproperty
   property p_other; OTHER_EVENT == |{EVENT_STATUS[13], EVENT_STATUS[8:6]}; endproperty
   property p_sum_cause; $rose(EVENT_STATUS[8]) |-> $past(EVENTS.checksum_done); endproperty
   property p_uv_edge; $changed(EVENTS.levels.undervoltage) |=> EVENT_STATUS[7]; endproperty
   property p_switch; EVENTS.switch_crossing || EVENTS.poll_first_done |=> EVENT_STATUS[3]; endproperty
   a_load_error: assert property (p_load_error) else $error("load error flags");
   a_init_order: assert property (p_init_order) else $error("init before check");
   a_reserved: assert property (p_reserved) else $error("reserved bit set");
   a_int_level: assert property (p_int_level) else $error("interrupt level");
   a_other: assert property (p_other) else $error("other event flag");
   a_sum_cause: assert property (p_sum_cause) else $error("checksum flag cause");
   a_uv_edge: assert property (p_uv_edge) else $error("undervoltage edge");
   a_switch: assert property (p_switch) else $error("switch change flag");
endmodule : event_status_chk

bind event_status_register_readclear event_status_chk u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N),
   .EVENTS(EVENTS), .INT_N(INT_N), .SELFCHECK_START(SELFCHECK_START), .INIT_DONE(INIT_DONE),
   .OTHER_EVENT(OTHER_EVENT), .EVENT_STATUS(EVENT_STATUS));

// file: bench/event_status_host.sv
`timescale 1ns/100ps
module event_status_host
   import event_status_pkg::*;
(
   // Clock and pins
   input  wire logic                     ref_clk,
   output var event_status_pkg::spi_in_s spi,
   input  wire logic                     so
);
   // ==========================================================
   // Frame driver, serial clock still outside frames
   initial spi = 3'h4;
   task automatic xfer(input logic wr, input logic [5:0] a, input int n, input logic bad,
                       output logic [31:0] r);
      logic [31:0] w;
      w = {wr, 1'b0, a, 24'h0};
      w[0] = ~^w[31:1] ^ bad;
      r = '0;
      spi.cs_n = 1'b0;
      repeat (8) @(negedge ref_clk);
      for (int i = 31; i > 31 - n; i--) begin
         spi.si = w[i];
         repeat (4) @(negedge ref_clk);
         spi.sclk = 1'b1;
         r = {r[30:0], so};
         repeat (4) @(negedge ref_clk);
         spi.sclk = 1'b0;
      end
      repeat (4) @(negedge ref_clk);
      spi.cs_n = 1'b1;
      // Released data line must not keep showing its last bit
      spi.si = ~spi.si;
      repeat (8) @(negedge ref_clk);
   endtask : xfer
endmodule : event_status_host

// file: bench/tb.sv
`timescale 1ns/100ps
module tb;
   import event_status_pkg::*;
   typedef struct packed {event_in_s ev; logic [23:0] exp;} row_s;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   event_in_s   ev = '0;
   spi_in_s     spi;
   logic        so, so_oe, int_n, sc_start, init_done, oth;
   logic [23:0] st;
   logic [31:0] r;
   int          miscompares = 0;
   int          n_tests = 0;
   int          cyc = 0;
   row_s        rows [11] = '{{10'h040, 24'h100}, {10'h020, 24'h8}, {10'h010, 24'h8}, {10'h008, 24'h80},
      {10'h000, 24'h80}, {10'h004, 24'h40}, {10'h000, 24'h40}, {10'h002, 24'h20}, {10'h000, 24'h20},
      {10'h001, 24'h10}, {10'h000, 24'h10}};
   event_status_register_readclear u_dut (.REF_CLK(ref_clk), .RST_N(rst_n), .SPI_IN(spi), .SO(so), .SO_OE(so_oe),
      .INT_N(int_n), .EVENTS(ev), .CHECKSUM_RESULT(16'hbeef), .SELFCHECK_START(sc_start),
      .INIT_DONE(init_done), .OTHER_EVENT(oth), .EVENT_STATUS(st));
   event_status_host u_host (.ref_clk(ref_clk), .spi(spi), .so(so));
   // ==========================================================
   // Helpers
   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         end_of_test;
      end
   end
   task cmp(input logic [23:0] g, input logic [23:0] e);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask : cmp
   task pulse(input logic [9:0] v);
      ev = v;
      @(negedge ref_clk);
      ev = {v[9], 5'h0, v[3:0]};
      @(negedge ref_clk);
   endtask : pulse
   task rd(input logic [5:0] a);
      u_host.xfer(1'b0, a, 32, 1'b0, r);
   endtask : rd
   task start(input logic err);
      rst_n = 1'b0;
      ev = '0;
      repeat (20) @(negedge ref_clk);
      rst_n = 1'b1;
      @(negedge ref_clk);
      cmp(st, STATUS_RESET);
      ev.factory_loaded = 1'b1;
      for (int i = 0; i < 50 && sc_start !== 1'b1; i++) @(negedge ref_clk);
      cmp(sc_start, 1'b1);
      pulse({2'h3, err, 7'h00});
      cmp(init_done, 1'b1);
      cmp(st, {10'h0, err, 12'h0, 1'b1});
      $display("startup done");
   endtask : start
   task end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   // ==========================================================
   // Sequence
   initial begin
      start(1'b1);
      cmp(oth, 1'b1);
      start(1'b0);
      rd(ADDR_EVENT_STATUS);
      cmp(r[23:0], STATUS_RESET);
      foreach (rows[i]) begin
         pulse(rows[i].ev | 10'h200);
         cmp(oth, |(rows[i].exp & 24'h0021c0));
         rd(ADDR_EVENT_STATUS);
         cmp(r[23:0], rows[i].exp);
         cmp(st, STATUS_CLEARED);
         cmp(int_n, 1'b1);
         cmp(so_oe, 1'b0);
         $display("row %0d done", i);
      end
      pulse(10'h240);
      u_host.xfer(1'b1, ADDR_EVENT_STATUS, 32, 1'b0, r);
      cmp(st, 24'h100);
      u_host.xfer(1'b0, ADDR_EVENT_STATUS, 32, 1'b1, r);
      cmp(st, 24'h104);
      u_host.xfer(1'b0, ADDR_EVENT_STATUS, 31, 1'b0, r);
      cmp(st, 24'h106);
      rd(ADDR_CHECKSUM);
      cmp(r[23:0], 24'h00beef);
      fork
         rd(ADDR_EVENT_STATUS);
         begin
            repeat (150) @(negedge ref_clk);
            cmp(so_oe, 1'b1);
            pulse(10'h220);
         end
      join
      cmp(r[23:0], 24'h106);
      cmp(r[31:24], 8'h70);
      cmp(st, 24'h8);
      cmp(int_n, 1'b0);
      $display("hand tests done");
      end_of_test;
   end
endmodule : tb
